// ---- verilog/eprom_prog_pkg.sv ----
// Constants for the EPROM program control block
package eprom_prog_pkg;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h1E;  // Register byte address
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam int          OPT_EN_BIT      = 2;
  localparam int          LATCH_BIT       = 1;
  localparam int          PULSE_BIT       = 0;
  localparam logic [7:0]  CTRL_WMASK      = 8'h07;  // Bits 7..3 read zero
  localparam logic [11:0] BOOT_ROM_LO     = 12'hE00;
  localparam logic [11:0] BOOT_ROM_HI     = 12'hFEF;
  localparam logic [11:0] OPT_BYTE0_ADDR  = 12'h200;
  localparam logic [11:0] OPT_BYTE1_ADDR  = 12'h201;
  localparam int          CLK_MHZ         = 200;
  localparam int          BYTE_PROG_US    = 1000;   // 1 ms per byte in bootload
  localparam int          BYTE_PROG_CYC   = BYTE_PROG_US * CLK_MHZ;
endpackage

// ---- verilog/eprom_program_control.sv ----
// EPROM program control register, write latches and bootloader sequencer
//
// Contract
// - Bootstrap mode is entered at reset release only with the test voltage present and boot pin low.
// - The bootloader code lives in ROM from 0E00 to 0FEF.
// - Bootstrap copies each external byte with one 1 ms program pass, then a verify pass.
// - An 8-bit program control register controls all EPROM programming; the bootloader program pulses bypass it.
// - Bit 2 set allows programming of option bytes 0200 and 0201; clear blocks CPU writes there, while the bootloader programs them regardless.
// - With latch mode clear the EPROM paths serve normal reads.
// - With latch mode set a CPU write to the EPROM latches its address and data.
// - With latch mode set the EPROM returns no valid read data.
// - Bit 0 switches programming power and is forced low whenever latch mode is clear.
// - Bits 7 to 3 read as zero and software writes zero there.
// - The option-byte store is two EPROM bytes selecting the mask-fixed features.
module eprom_program_control #(
  parameter int BYTE_CYCLES = eprom_prog_pkg::BYTE_PROG_CYC,
  parameter int ADDR_W      = 12
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic              TEST_VOLTAGE_LEVEL_I,
  input  wire logic              BOOT_SELECT_PIN_I,
  input  wire logic              REG_WE_I,
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [7:0]        REG_WDATA_I,
  output logic      [7:0]        REG_RDATA_O,
  input  wire logic              MEM_WE_I,
  input  wire logic [ADDR_W-1:0] MEM_ADDR_I,
  input  wire logic [7:0]        MEM_WDATA_I,
  input  wire logic [7:0]        ARRAY_RDATA_I,
  output logic      [7:0]        MEM_RDATA_O,
  output logic                   MEM_RVALID_O,
  output logic      [ADDR_W-1:0] LATCH_ADDR_O,
  output logic      [7:0]        LATCH_DATA_O,
  output logic                   PROGRAM_POWER_O,
  output logic                   BOOT_MODE_O,
  output logic                   BOOT_ROM_SEL_O,
  input  wire logic              EXT_VALID_I,
  input  wire logic [7:0]        EXT_DATA_I,
  output logic      [ADDR_W-1:0] EXT_ADDR_O,
  output logic                   BOOT_BUSY_O,
  output logic                   BOOT_DONE_O,
  output logic                   BOOT_FAIL_O
);
  import eprom_prog_pkg::*;

  typedef enum logic [2:0] {B_IDLE, B_FETCH, B_PULSE, B_VERIFY, B_DONE} boot_state_t;

  logic [2:0]        ctrl_ff;
  logic              rst_d_ff;
  logic              boot_ff;
  boot_state_t       bst_ff;
  logic [ADDR_W-1:0] baddr_ff;
  logic [31:0]       bcnt_ff;
  logic              fail_ff;
  logic [ADDR_W-1:0] laddr_ff;
  logic [7:0]        ldata_ff;
  logic              reg_hit;
  logic              latch_mode;
  logic              opt_blocked;
  logic [7:0]        nxt_ctrl;

  // Option bytes need the enable bit; decoded for CPU writes only, boot writes bypass it
  function automatic logic is_opt_addr(input logic [ADDR_W-1:0] a);
    return (a == OPT_BYTE0_ADDR[ADDR_W-1:0]) || (a == OPT_BYTE1_ADDR[ADDR_W-1:0]);
  endfunction

  assign reg_hit     = REG_WE_I && (REG_ADDR_I == CTRL_OFFSET);
  assign latch_mode  = ctrl_ff[LATCH_BIT] || (bst_ff == B_PULSE);
  assign opt_blocked = is_opt_addr(MEM_ADDR_I) && !ctrl_ff[OPT_EN_BIT];

  // Pulse bit cannot be held without latch mode in the same written value
  always_comb begin
    nxt_ctrl = REG_WDATA_I & CTRL_WMASK;
    if (!nxt_ctrl[LATCH_BIT]) begin
      nxt_ctrl[PULSE_BIT] = 1'b0;
    end
  end

  // Control register; a boot sequence owns the array so CPU writes are dropped
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_ff <= CTRL_RESET[2:0];
    end else if (reg_hit && !boot_ff) begin
      ctrl_ff <= nxt_ctrl[2:0];
    end
  end

  assign REG_RDATA_O = (REG_ADDR_I == CTRL_OFFSET) ? {5'h00, ctrl_ff} : 8'h00;

  // Strap caught on the first clock after reset release, not under reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rst_d_ff <= 1'b1;
      boot_ff  <= 1'b0;
    end else begin
      rst_d_ff <= 1'b0;
      if (rst_d_ff) begin
        boot_ff <= TEST_VOLTAGE_LEVEL_I && !BOOT_SELECT_PIN_I;
      end
    end
  end

  // Address and data latches; blocked option-byte writes leave them alone
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      laddr_ff <= '0;
      ldata_ff <= 8'h00;
    end else if (bst_ff == B_FETCH && EXT_VALID_I) begin
      laddr_ff <= baddr_ff;
      ldata_ff <= EXT_DATA_I;
    end else if (ctrl_ff[LATCH_BIT] && MEM_WE_I && !opt_blocked) begin
      laddr_ff <= MEM_ADDR_I;
      ldata_ff <= MEM_WDATA_I;
    end
  end

  // Bootloader: one program pass over every address, then one verify pass
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bst_ff   <= B_IDLE;
      baddr_ff <= '0;
      bcnt_ff  <= '0;
      fail_ff  <= 1'b0;
    end else begin
      case (bst_ff)
        B_IDLE: begin
          if (boot_ff) begin
            bst_ff <= B_FETCH;
          end
        end
        B_FETCH: begin
          if (EXT_VALID_I) begin
            bst_ff  <= B_PULSE;
            bcnt_ff <= '0;
          end
        end
        B_PULSE: begin
          if (bcnt_ff == 32'(BYTE_CYCLES - 1)) begin
            baddr_ff <= baddr_ff + 1'b1;
            bst_ff   <= (baddr_ff == '1) ? B_VERIFY : B_FETCH;
          end else begin
            bcnt_ff <= bcnt_ff + 32'd1;
          end
        end
        B_VERIFY: begin
          if (EXT_VALID_I) begin
            if (EXT_DATA_I != ARRAY_RDATA_I) begin
              fail_ff <= 1'b1;
            end
            baddr_ff <= baddr_ff + 1'b1;
            if (baddr_ff == '1) begin
              bst_ff <= B_DONE;
            end
          end
        end
        B_DONE: bst_ff <= B_DONE;
        default: bst_ff <= B_IDLE;
      endcase
    end
  end

  assign PROGRAM_POWER_O = (ctrl_ff[PULSE_BIT] && ctrl_ff[LATCH_BIT]) || (bst_ff == B_PULSE);
  assign MEM_RVALID_O    = !latch_mode;
  assign MEM_RDATA_O     = latch_mode ? 8'h00 : ARRAY_RDATA_I;
  assign LATCH_ADDR_O    = laddr_ff;
  assign LATCH_DATA_O    = ldata_ff;
  assign BOOT_MODE_O     = boot_ff;
  assign BOOT_ROM_SEL_O  = (MEM_ADDR_I >= BOOT_ROM_LO[ADDR_W-1:0]) &&
                           (MEM_ADDR_I <= BOOT_ROM_HI[ADDR_W-1:0]);
  assign EXT_ADDR_O      = baddr_ff;
  assign BOOT_BUSY_O     = (bst_ff != B_IDLE) && (bst_ff != B_DONE);
  assign BOOT_DONE_O     = (bst_ff == B_DONE);
  assign BOOT_FAIL_O     = fail_ff;

  // Checks
  property p_pulse_needs_latch;
    @(posedge CLK_I) disable iff (RST_I) !ctrl_ff[LATCH_BIT] |-> !ctrl_ff[PULSE_BIT];
  endproperty
  pulse_needs_latch_a: assert property (p_pulse_needs_latch) else $error("pulse without latch");
  reserved_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    REG_ADDR_I == CTRL_OFFSET |-> REG_RDATA_O[7:3] == 5'h00) else $error("reserved bits set");
  reg_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    reg_hit && !boot_ff |=> ctrl_ff[LATCH_BIT] == $past(REG_WDATA_I[LATCH_BIT]))
    else $error("latch bit not written");
  opt_block_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bst_ff == B_IDLE && ctrl_ff[LATCH_BIT] && MEM_WE_I && opt_blocked |=> $stable(laddr_ff))
    else $error("option byte latched while blocked");
  latch_capture_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bst_ff == B_IDLE && ctrl_ff[LATCH_BIT] && MEM_WE_I && !opt_blocked
    |=> laddr_ff == $past(MEM_ADDR_I) && ldata_ff == $past(MEM_WDATA_I))
    else $error("write not latched");
  no_read_latch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    latch_mode |-> !MEM_RVALID_O) else $error("read valid in latch mode");
  normal_read_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !latch_mode |-> MEM_RVALID_O && MEM_RDATA_O == ARRAY_RDATA_I)
    else $error("normal read broken");
  boot_entry_a: assert property (@(posedge CLK_I)
    $fell(RST_I) |=> boot_ff == $past(TEST_VOLTAGE_LEVEL_I && !BOOT_SELECT_PIN_I))
    else $error("boot strap wrong");
  pulse_len_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bst_ff == B_FETCH && EXT_VALID_I |=> PROGRAM_POWER_O [*2])
    else $error("boot pulse too short");
  rom_sel_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    MEM_ADDR_I == BOOT_ROM_LO[ADDR_W-1:0] |-> BOOT_ROM_SEL_O) else $error("boot rom decode");
  // Pulse counter must never run past the per-byte time, or the byte is overcooked
  pulse_count_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bst_ff == B_PULSE |-> bcnt_ff < 32'(BYTE_CYCLES))
    else $error("boot pulse overrun");
  fail_sticky_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    fail_ff |=> fail_ff) else $error("verify fail lost");

  boot_cov_c:  cover property (@(posedge CLK_I) disable iff (RST_I) $rose(boot_ff));
  prog_cov_c:  cover property (@(posedge CLK_I) disable iff (RST_I) $rose(PROGRAM_POWER_O));
  verif_cov_c: cover property (@(posedge CLK_I) disable iff (RST_I) bst_ff == B_VERIFY);
  opt_cov_c:   cover property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_ff[OPT_EN_BIT] && ctrl_ff[LATCH_BIT] && MEM_WE_I && is_opt_addr(MEM_ADDR_I));
endmodule

// ---- dv/test_eprom_program_control.sv ----
// Self-checking bench for the EPROM program control block
module test_eprom_program_control;
  timeunit 1ns;
  timeprecision 1ps;
  import eprom_prog_pkg::*;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        tv    = 1'b1;
  logic        bp    = 1'b1;
  logic        rwe   = 1'b0;
  logic        mwe   = 1'b0;
  logic        bdrv  = 1'b0;
  logic [7:0]  raddr = 8'h00;
  logic [7:0]  rwd   = 8'h00;
  logic [7:0]  mwd   = 8'h00;
  logic [7:0]  ard   = 8'hC3;
  logic [7:0]  edat  = 8'h00;
  logic [11:0] maddr = 12'h000;
  logic [15:0] pw    = 16'h0000;
  logic [7:0]  rrd, mrd, ldat;
  logic [11:0] ladr, eadr;
  logic        mrv, pwr, bmode, bsel, busy, done, fail;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          cyc        = 0;
  logic [11:0] rom_a [4];
  logic        rom_e [4];

  eprom_program_control #(.BYTE_CYCLES(4), .ADDR_W(12)) eprom_program_control_i (
    .CLK_I(clk), .RST_I(rst), .TEST_VOLTAGE_LEVEL_I(tv), .BOOT_SELECT_PIN_I(bp),
    .REG_WE_I(rwe), .REG_ADDR_I(raddr), .REG_WDATA_I(rwd), .REG_RDATA_O(rrd),
    .MEM_WE_I(mwe), .MEM_ADDR_I(maddr), .MEM_WDATA_I(mwd), .ARRAY_RDATA_I(ard),
    .MEM_RDATA_O(mrd), .MEM_RVALID_O(mrv), .LATCH_ADDR_O(ladr), .LATCH_DATA_O(ldat),
    .PROGRAM_POWER_O(pwr), .BOOT_MODE_O(bmode), .BOOT_ROM_SEL_O(bsel),
    .EXT_VALID_I(bdrv), .EXT_DATA_I(edat), .EXT_ADDR_O(eadr),
    .BOOT_BUSY_O(busy), .BOOT_DONE_O(done), .BOOT_FAIL_O(fail));

  always #2.5 clk = ~clk;

  // External image holds each byte at its own address; array echoes it back
  always @(negedge clk) begin
    ard  <= bdrv ? eadr[7:0] : 8'hC3;
    edat <= eadr[7:0];
  end

  // Cycle ceiling covers a full program and verify pass with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bdrv && pwr === 1'b1) pw <= pw + 16'h0001;
    if (cyc == 50000) begin
      n_mismatch++;
      test_done();
    end
  end

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe held over exactly one rising edge
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); rwe = 1'b1; raddr = a; rwd = d;
    @(negedge clk); rwe = 1'b0;
  endtask

  task reg_rd(input logic [7:0] a, input logic [7:0] exp);
    raddr = a;
    #1 cmp(rrd, exp);
  endtask

  task mem_wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk); mwe = 1'b1; maddr = a; mwd = d;
    @(negedge clk); mwe = 1'b0;
  endtask

  task do_rst(input logic t, input logic b);
    @(negedge clk); rst = 1'b1; tv = t; bp = b;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rom_a = '{BOOT_ROM_LO, BOOT_ROM_HI, BOOT_ROM_LO - 12'h001, BOOT_ROM_HI + 12'h001};
    rom_e = '{1'b1, 1'b1, 1'b0, 1'b0};
    do_rst(1'b1, 1'b1);
    cmp(bmode, 0);
    reg_rd(CTRL_OFFSET, CTRL_RESET);
    reg_wr(CTRL_OFFSET, 8'hFF); reg_rd(CTRL_OFFSET, 8'h07);
    reg_rd(8'h1F, 8'h00);
    reg_wr(CTRL_OFFSET, 8'h01); reg_rd(CTRL_OFFSET, 8'h00);
    cmp(pwr, 0);
    mem_wr(12'h0AB, 8'h11); cmp(ldat, 8'h00);
    cmp(mrv, 1); cmp(mrd, 8'hC3);
    reg_wr(CTRL_OFFSET, 8'h02); cmp(mrv, 0); cmp(mrd, 8'h00);
    mem_wr(12'h123, 8'h55); cmp(ladr, 12'h123); cmp(ldat, 8'h55);
    mem_wr(OPT_BYTE0_ADDR, 8'hAA); cmp(ladr, 12'h123); cmp(ldat, 8'h55);
    reg_wr(CTRL_OFFSET, 8'h03); cmp(pwr, 1);
    repeat (4) @(negedge clk);
    cmp(pwr, 1);
    reg_wr(CTRL_OFFSET, 8'h02); cmp(pwr, 0); cmp(mrv, 0);
    reg_wr(CTRL_OFFSET, 8'h00); cmp(mrv, 1);
    reg_wr(CTRL_OFFSET, 8'h06); mem_wr(OPT_BYTE1_ADDR, 8'h3C);
    cmp(ladr, OPT_BYTE1_ADDR); cmp(ldat, 8'h3C);
    for (int i = 0; i < 4; i++) begin
      maddr = rom_a[i];
      #1 cmp(bsel, rom_e[i]);
    end
    do_rst(1'b0, 1'b0); cmp(bmode, 0);
    do_rst(1'b1, 0); cmp(bmode, 1);
    // Register must stay shut while the sequencer owns the array
    reg_wr(CTRL_OFFSET, 8'h02); reg_rd(CTRL_OFFSET, 8'h00);
    bdrv = 1'b1;
    repeat (2) @(negedge clk);
    cmp(busy, 1);
    for (int i = 0; i < 30000 && done !== 1'b1; i++) @(negedge clk);
    cmp(done, 1); cmp(fail, 0);
    cmp(busy, 0);
    cmp(ladr, 12'hFFF);
    cmp(ldat, 8'hFF);
    cmp(pw, 16'd16384);
    test_done();
  end
endmodule
